// ### rtl/msc_ctrl.v
// Memory access ordering, atomicity and speculative fetch control.
// Assumes one core clock, a Wishbone classic master for the registers,
// a load/store unit holding ls_req until ls_done, and a fetch unit
// holding fch_req until fch_gnt or fch_isi.
`timescale 1ns/1ps
`include "msc_map.vh"

module msc_ctrl #(
  parameter MT_W = 4
) (
  input  wire        ref_clk,
  input  wire        rst_b,

  // Register bus
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,

  // Load/store unit
  input  wire        ls_req,
  input  wire [2:0]  ls_kind,
  input  wire [1:0]  ls_size,
  input  wire        ls_we,
  input  wire [31:0] ls_addr,
  input  wire [31:0] ls_wdata,
  input  wire        ls_spec,
  input  wire        ls_cached,
  output reg         ls_done,
  output reg  [31:0] ls_rdata,
  output reg         stwcx_ok,

  // Memory side
  output reg         mem_req,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  output reg  [1:0]  mem_size,
  output reg         mem_atomic,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  output reg         resv_notify,

  // Instruction fetch unit
  input  wire        fch_req,
  input  wire [31:0] fch_addr,
  input  wire        fch_spec,
  input  wire        fch_seq,
  input  wire        fch_hit,
  input  wire        fch_cacheable,
  input  wire        tlb_guard,
  input  wire        tlb_noexec,
  output reg         fch_gnt,
  output reg         fch_isi,

  // Branch and trap state
  input  wire        br_unresolved,
  input  wire        br_resolve,
  input  wire        br_mispredict,
  input  wire        uncond_br_fetched,
  input  wire        redirect,
  input  wire        ind_br_pred,
  input  wire        mt_issue,
  input  wire        mt_done,
  input  wire        trap_exec,
  output reg         flush
);

  localparam ST_IDLE = 1'b0;
  localparam ST_BUS  = 1'b1;
  localparam PG_W    = 32 - `MSC_PAGE_LSB;
  localparam [31:0] GUARD_RST = `MSC_GUARD_RST;

  // Register file
  reg             ir_r;
  reg  [31:0]     guard_r;
  reg  [31:0]     rd_nxt;
  wire            wb_hit;
  wire            wb_wr;

  // Load/store path
  reg             state_r;
  reg             state_nxt;
  reg             resv_r;
  reg  [31:0]     resv_addr_r;
  reg             atomic_nxt;
  wire            word_kind;
  wire [31:0]     ls_eff_addr;
  wire            spec_hold;

  // Fetch path
  reg  [2:0]      spec_cnt_r;
  reg  [MT_W-1:0] mt_cnt_r;
  reg             seq_stop_r;
  reg             trap_r;
  reg  [PG_W-1:0] last_pg_r;
  reg             pg_valid_r;
  wire [PG_W-1:0] fch_pg;
  wire [2:0]      spec_lim;
  wire            guarded;
  wire            page_ok;
  wire            fetch_blk;
  reg             fetch_ok;
  wire            fault;
  wire            fch_idle;

  // Wishbone slave: one wait state, ack for one cycle
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_hit & wb_we_i;

  always @* begin
    if (wb_adr_i == `MSC_OFS_CTRL) begin
      rd_nxt = {31'h0000_0000, ir_r};
    end else if (wb_adr_i == `MSC_OFS_GUARD) begin
      rd_nxt = guard_r;
    end else if (wb_adr_i == `MSC_OFS_STAT) begin
      // Snapshot of live ordering and fetch state
      rd_nxt = 32'h0000_0000;
      rd_nxt[`MSC_ST_RESV] = resv_r;
      rd_nxt[`MSC_ST_BUSY] = state_r;
      rd_nxt[`MSC_ST_IR] = ir_r;
      rd_nxt[`MSC_ST_SPEC_LSB +: 3] = spec_cnt_r;
      rd_nxt[`MSC_ST_MT_LSB +: 4] = mt_cnt_r[3:0];
      rd_nxt[`MSC_ST_SEQSTOP] = seq_stop_r;
      rd_nxt[`MSC_ST_TRAP] = trap_r;
    end else if (wb_adr_i == `MSC_OFS_RESV) begin
      rd_nxt = resv_addr_r;
    end else begin
      rd_nxt = 32'h0000_0000;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ir_r     <= `MSC_CTRL_RST;
    end else begin
      wb_ack_o <= wb_hit;
      if (wb_hit && !wb_we_i) begin
        wb_dat_o <= rd_nxt;
      end

      // Relocate bit lives in byte lane 0
      if (wb_wr && wb_adr_i == `MSC_OFS_CTRL && wb_sel_i[0]) begin
        ir_r <= wb_dat_i[`MSC_CTRL_IR];
      end
    end
  end

  // One write lane per byte of the region register
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_guard
      always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          guard_r[gi*8 +: 8] <= GUARD_RST[gi*8 +: 8];
        end else if (wb_wr && wb_adr_i == `MSC_OFS_GUARD && wb_sel_i[gi]) begin
          guard_r[gi*8 +: 8] <= wb_dat_i[gi*8 +: 8];
        end
      end
    end
  endgenerate

  // Load/store ordering and atomicity
  assign word_kind   = (ls_kind == `MSC_K_LRES) || (ls_kind == `MSC_K_SCOND);
  assign ls_eff_addr = word_kind ? {ls_addr[31:2], 2'b00} : ls_addr;
  // Only a load that hits the cache may run ahead of resolution
  assign spec_hold   = ls_spec & ~(ls_cached & ~ls_we);

  always @* begin
    atomic_nxt = 1'b0;
    if (ls_kind == `MSC_K_NORM || word_kind) begin
      case (word_kind ? `MSC_SZ_WORD : ls_size)
        `MSC_SZ_BYTE: atomic_nxt = 1'b1;
        `MSC_SZ_HALF: atomic_nxt = ~ls_eff_addr[0];
        `MSC_SZ_WORD: atomic_nxt = ls_eff_addr[1:0] == 2'b00;
        default:      atomic_nxt = 1'b0;
      endcase
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (ls_req && !ls_done && !spec_hold && !br_mispredict &&
            ls_kind != `MSC_K_IOBAR && ls_kind != `MSC_K_FSYNC &&
            !(ls_kind == `MSC_K_SCOND && !resv_r)) begin
          state_nxt = ST_BUS;
        end
      end
      ST_BUS: begin
        if (mem_ack) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r     <= ST_IDLE;
      ls_done     <= 1'b0;
      ls_rdata    <= 32'h0000_0000;
      stwcx_ok    <= 1'b0;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= 32'h0000_0000;
      mem_wdata   <= 32'h0000_0000;
      mem_size    <= `MSC_SZ_BYTE;
      mem_atomic  <= 1'b0;
      resv_r      <= 1'b0;
      resv_addr_r <= 32'h0000_0000;
      resv_notify <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      ls_done     <= 1'b0;
      resv_notify <= 1'b0;

      // Take a new request from the load/store unit
      if (state_r == ST_IDLE && ls_req && !ls_done && !br_mispredict) begin
        if (ls_kind == `MSC_K_IOBAR || ls_kind == `MSC_K_FSYNC) begin
          // One access in flight at most, so idle means all earlier done
          ls_done  <= 1'b1;
          stwcx_ok <= 1'b0;
        end else if (ls_kind == `MSC_K_SCOND && !resv_r) begin
          ls_done  <= 1'b1;
          stwcx_ok <= 1'b0;
        end else if (!spec_hold) begin
          mem_req    <= 1'b1;
          mem_we     <= ls_we | (ls_kind == `MSC_K_SCOND);
          mem_addr   <= ls_eff_addr;
          mem_wdata  <= ls_wdata;
          mem_size   <= word_kind ? `MSC_SZ_WORD : ls_size;
          mem_atomic <= atomic_nxt;
        end
      end

      // Memory answer closes the access
      if (state_r == ST_BUS && mem_ack) begin
        mem_req  <= 1'b0;
        ls_done  <= 1'b1;
        ls_rdata <= mem_rdata;
        stwcx_ok <= mem_we & (mem_addr == resv_addr_r) & resv_r;
        if (!mem_we && mem_size == `MSC_SZ_WORD && mem_atomic &&
            mem_addr == ls_eff_addr && ls_kind == `MSC_K_LRES) begin
          resv_addr_r <= mem_addr;
          resv_notify <= 1'b1;
        end
      end

      // Reservation is local only; no snoop clears it
      if (state_r == ST_BUS && mem_ack && ls_kind == `MSC_K_LRES) begin
        resv_r <= 1'b1;
      end else if (ls_done && ls_kind == `MSC_K_SCOND) begin
        resv_r <= 1'b0;
      end
    end
  end

  // Instruction fetch speculation control
  assign fch_pg   = fch_addr[31:`MSC_PAGE_LSB];
  // Grant limit past an open branch depends on cacheability
  assign spec_lim = fch_cacheable ? `MSC_SPEC_CACHED : `MSC_SPEC_NONC;
  assign guarded  = ir_r ? tlb_guard : guard_r[fch_addr[31:`MSC_REGION_LSB]];
  // Same or next 1 KB page as the last granted fetch
  assign page_ok  = pg_valid_r &&
                    (fch_pg == last_pg_r || fch_pg == last_pg_r + 1'b1);
  assign fch_idle = fch_req & ~fch_gnt & ~fch_isi & ~br_mispredict;

  // System call and interrupt return add no stop term here
  assign fetch_blk = fch_spec && (
      trap_r ||
      (ind_br_pred && mt_cnt_r != {MT_W{1'b0}}) ||
      (seq_stop_r && fch_seq) ||
      (br_unresolved && spec_cnt_r >= spec_lim));

  // Virtual mode faults on a guarded or no-execute page unless the line is already cached
  assign fault = ir_r & (tlb_guard | tlb_noexec) & ~fch_hit;

  // Guarded handling differs by translation mode
  always @* begin
    if (fetch_blk) begin
      fetch_ok = 1'b0;
    end else if (ir_r) begin
      fetch_ok = ~fault;
    end else if (!guarded || !fch_spec) begin
      fetch_ok = 1'b1;
    end else if (fch_hit) begin
      fetch_ok = 1'b1;
    end else begin
      fetch_ok = fch_seq & page_ok;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fch_gnt    <= 1'b0;
      fch_isi    <= 1'b0;
      flush      <= 1'b0;
      spec_cnt_r <= 3'h0;
      mt_cnt_r   <= {MT_W{1'b0}};
      seq_stop_r <= 1'b0;
      trap_r     <= 1'b0;
      last_pg_r  <= {PG_W{1'b0}};
      pg_valid_r <= 1'b0;
    end else begin
      fch_gnt <= fch_idle & fetch_ok;
      // Fault only once the fetch is really required
      fch_isi <= fch_idle & fault & ~fch_spec;
      flush   <= br_mispredict;
      trap_r  <= trap_exec;

      // Page of the last granted fetch
      if (fch_idle && fetch_ok) begin
        last_pg_r  <= fch_pg;
        pg_valid_r <= 1'b1;
      end

      // Speculative grants past the open branch
      if (br_resolve || br_mispredict) begin
        spec_cnt_r <= 3'h0;
      end else if (fch_idle && fetch_ok && fch_spec && br_unresolved) begin
        spec_cnt_r <= spec_cnt_r + 3'h1;
      end

      // Sequential stop after an unconditional branch
      if (uncond_br_fetched) begin
        seq_stop_r <= 1'b1;
      end else if (redirect || br_mispredict) begin
        seq_stop_r <= 1'b0;
      end

      // Pending count/link register moves
      if (mt_issue && !mt_done) begin
        mt_cnt_r <= mt_cnt_r + 1'b1;
      end else if (mt_done && !mt_issue && mt_cnt_r != {MT_W{1'b0}}) begin
        mt_cnt_r <= mt_cnt_r - 1'b1;
      end
    end
  end

endmodule // msc_ctrl

// ### rtl/msc_map.vh
// Constants for the memory ordering and speculation control block.
// Included by msc_ctrl.v; holds definitions only.
`ifndef MSC_MAP_VH
`define MSC_MAP_VH

// Register byte offsets on the Wishbone slave
`define MSC_OFS_CTRL    8'h00
`define MSC_OFS_GUARD   8'h04
`define MSC_OFS_STAT    8'h08
`define MSC_OFS_RESV    8'h0c

// Control register fields and reset values
`define MSC_CTRL_IR     0
`define MSC_CTRL_RST    1'b0
`define MSC_GUARD_RST   32'h0000_0000

// Status register field positions
`define MSC_ST_RESV     0
`define MSC_ST_BUSY     1
`define MSC_ST_IR       2
`define MSC_ST_SPEC_LSB 4
`define MSC_ST_MT_LSB   8
`define MSC_ST_SEQSTOP  12
`define MSC_ST_TRAP     13

// Access kinds presented by the load/store unit
`define MSC_K_NORM      3'h0
`define MSC_K_MULT      3'h1
`define MSC_K_CMGT      3'h2
`define MSC_K_LRES      3'h3
`define MSC_K_SCOND     3'h4
`define MSC_K_IOBAR     3'h5
`define MSC_K_FSYNC     3'h6

// Access sizes
`define MSC_SZ_BYTE     2'h0
`define MSC_SZ_HALF     2'h1
`define MSC_SZ_WORD     2'h2

// Speculative fetch limits past an unresolved branch
`define MSC_SPEC_CACHED 3'h5
`define MSC_SPEC_NONC   3'h2

// Real-mode page and guarded region address slicing
`define MSC_PAGE_LSB    10
`define MSC_REGION_LSB  27

`endif

// ### sim/msc_mem_model.sv
// Far-side memory model for msc_ctrl: sixteen words, stores and loads.
// Assumes mem_req is held until the edge after mem_ack; waits 0 to 3 cycles.
`timescale 1ns/1ps
module msc_mem_model (
  input  logic        ref_clk,
  input  logic        rst_b,
  input  logic        mem_req,
  input  logic        mem_we,
  input  logic [31:0] mem_addr,
  input  logic [31:0] mem_wdata,
  output logic        mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] word_r [0:15];
  logic [1:0]  wait_r;
  initial for (int i = 0; i < 16; i++) word_r[i] = 32'h0;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0;
      wait_r    <= 2'h0;
    end else if (mem_req && !mem_ack && wait_r == 2'h0) begin
      mem_ack <= 1'b1;
      wait_r  <= 2'($urandom_range(0, 3));
      if (mem_we)
        word_r[mem_addr[5:2]] <= mem_wdata;
      else
        mem_rdata <= word_r[mem_addr[5:2]];
    end else begin
      // Read data is only meaningful with mem_ack
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        wait_r <= wait_r - 2'h1;
    end
  end
endmodule // msc_mem_model

// ### sim/msc_ctrl_asserts.sv
// Checker for msc_ctrl: ordering, reservation and fetch throttle relations.
// Sees only msc_ctrl ports; bound to every instance below.
`timescale 1ns/1ps
`include "msc_map.vh"
module msc_ctrl_chk (
  input logic        ref_clk,
  input logic        rst_b,
  input logic        ls_req,
  input logic [2:0]  ls_kind,
  input logic        ls_spec,
  input logic        ls_cached,
  input logic        ls_done,
  input logic        stwcx_ok,
  input logic        mem_req,
  input logic [31:0] mem_addr,
  input logic [1:0]  mem_size,
  input logic        mem_atomic,
  input logic        resv_notify,
  input logic        fch_gnt,
  input logic        fch_spec,
  input logic        fch_cacheable,
  input logic        br_unresolved,
  input logic        br_mispredict,
  input logic        trap_exec,
  input logic        flush
);
  logic       resv_r;
  logic [2:0] spec_cnt_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Reservation and speculative grant count as seen at the ports
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      resv_r     <= 1'b0;
      spec_cnt_r <= 3'h0;
    end else begin
      if (resv_notify)
        resv_r <= 1'b1;
      else if (ls_done && ls_kind == `MSC_K_SCOND)
        resv_r <= 1'b0;
      if (!br_unresolved)
        spec_cnt_r <= 3'h0;
      else if (fch_gnt && fch_spec)
        spec_cnt_r <= spec_cnt_r + 3'h1;
    end
  end
  chk_atomic_aligned : assert property (
    mem_req && ls_kind == `MSC_K_NORM && mem_addr[1:0] == 2'h0 |-> mem_atomic)
    else $error("aligned access not indivisible");
  chk_resv_word : assert property (
    mem_req && (ls_kind == `MSC_K_LRES || ls_kind == `MSC_K_SCOND) |-> mem_size == `MSC_SZ_WORD)
    else $error("reserved access not word sized");
  chk_resv_notify : assert property (
    resv_notify |-> ls_done && ls_kind == `MSC_K_LRES) else $error("stray reservation notice");
  chk_scond_nores : assert property (
    $rose(ls_req) && ls_kind == `MSC_K_SCOND && !resv_r |=> ls_done && !mem_req && !stwcx_ok)
    else $error("conditional store without reservation");
  chk_barrier_done : assert property (
    $rose(ls_req) && (ls_kind == `MSC_K_IOBAR || ls_kind == `MSC_K_FSYNC) |=> ls_done && !mem_req)
    else $error("barrier not done in one cycle");
  chk_spec_held : assert property (
    ls_req && ls_spec && !ls_cached && !mem_req && !ls_done |=> !mem_req)
    else $error("speculative access reached memory");
  chk_spec_limit : assert property (
    fch_gnt && fch_spec && br_unresolved |->
      spec_cnt_r < (fch_cacheable ? `MSC_SPEC_CACHED : `MSC_SPEC_NONC))
    else $error("speculative fetch limit exceeded");
  chk_trap_block : assert property (
    trap_exec ##1 trap_exec |=> !fch_gnt) else $error("fetch granted during trap");
  chk_flush_follow : assert property (
    br_mispredict |=> flush) else $error("no flush after mispredict");
endmodule // msc_ctrl_chk

bind msc_ctrl msc_ctrl_chk i_chk (.ref_clk, .rst_b, .ls_req, .ls_kind, .ls_spec, .ls_cached,
  .ls_done, .stwcx_ok, .mem_req, .mem_addr, .mem_size, .mem_atomic, .resv_notify, .fch_gnt,
  .fch_spec,
  .fch_cacheable, .br_unresolved, .br_mispredict, .trap_exec, .flush);

// ### sim/testbench.sv
// Self-checking bench for msc_ctrl with the memory model on the far side.
// Assumes the checker is bound from msc_ctrl_asserts.sv.
`timescale 1ns/1ps
`include "msc_map.vh"
module testbench;
  logic        ref_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, ls_req, ls_we;
  logic        ls_spec, ls_cached, ls_done, stwcx_ok, mem_req, mem_we, mem_atomic, mem_ack;
  logic        resv_notify, fch_req, fch_spec, fch_seq, fch_hit, fch_cacheable, tlb_guard;
  logic        tlb_noexec, fch_gnt, fch_isi, br_unresolved, br_resolve, br_mispredict;
  logic        uncond_br_fetched, redirect, ind_br_pred, mt_issue, mt_done, trap_exec, flush;
  logic [1:0]  ls_size, mem_size;
  logic [2:0]  ls_kind;
  logic [3:0]  wb_sel_i;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, ls_addr, ls_wdata, ls_rdata, mem_addr, mem_wdata;
  logic [31:0] mem_rdata, fch_addr, d0, d1;
  logic [33:0] lq[$];
  logic [31:0] wq[$];
  logic [1:0]  fq[$];
  int          n_mismatch = 0;
  int          total_checks = 0;

  msc_ctrl i_dut (.ref_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .ls_req, .ls_kind, .ls_size, .ls_we, .ls_addr, .ls_wdata,
    .ls_spec, .ls_cached, .ls_done, .ls_rdata, .stwcx_ok, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_size, .mem_atomic, .mem_ack, .mem_rdata, .resv_notify, .fch_req,
    .fch_addr, .fch_spec, .fch_seq, .fch_hit, .fch_cacheable, .tlb_guard, .tlb_noexec,
    .fch_gnt, .fch_isi, .br_unresolved, .br_resolve, .br_mispredict, .uncond_br_fetched,
    .redirect, .ind_br_pred, .mt_issue, .mt_done, .trap_exec, .flush);
  msc_mem_model i_mem (.ref_clk, .rst_b, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_ack, .mem_rdata);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [33:0] e, input logic [33:0] s, input string n);
    total_checks++;
    if (e !== s) begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      n_mismatch++;
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Oldest note is matched against each result as it appears
  always @(posedge ref_clk) begin : mon
    logic [33:0] e;
    if (ls_done) begin
      e = lq.pop_front();
      chk(e, {e[33], stwcx_ok, e[33] ? ls_rdata : e[31:0]}, "load_store");
    end
    if (wb_ack_o && !wb_we_i)
      chk(wq.pop_front(), wb_dat_o, "register_read");
    if (fch_gnt || fch_isi)
      chk(fq.pop_front(), {fch_gnt, fch_isi}, "fetch");
  end

  task automatic wt(input bit sel);
    int i = 0;
    do @(posedge ref_clk); while ((sel ? ls_done : wb_ack_o) !== 1'b1 && ++i < 200);
    if (i == 200)
      n_mismatch++;
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    if (!we)
      wq.push_back(d);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    wt(1'b0);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge ref_clk);
  endtask

  // Note bits: read data checked, conditional store result, data
  task automatic ls(input logic [2:0] kd, input logic we, input logic sp, input logic [33:0] e);
    lq.push_back(e);
    {ls_req, ls_kind, ls_we, ls_spec, ls_wdata} <= {1'b1, kd, we, sp, e[31:0]};
    if (sp) begin
      repeat (6) @(posedge ref_clk);
      chk(34'h0, {33'h0, mem_req}, "spec_hold");
      ls_spec <= 1'b0;
    end
    wt(1'b1);
    ls_req <= 1'b0;
    @(posedge ref_clk);
  endtask

  // q is spec, seq, hit, cacheable; blockers are lifted after hold cycles
  task automatic fch(input logic [3:0] q, input logic [1:0] e, input int hold);
    int k = 0;
    fq.push_back(e);
    {fch_req, fch_spec, fch_seq, fch_hit, fch_cacheable, fch_addr} <= {1'b1, q, $urandom};
    do begin
      @(posedge ref_clk);
      {br_resolve, redirect, mt_done} <= {3{k == hold}};
      if (k == hold)
        {br_unresolved, trap_exec} <= 2'h0;
    end while (!(fch_gnt || fch_isi) && ++k < 200);
    chk(34'h1, {33'h0, k > hold || hold > 90}, "fetch_hold");
    fch_req <= 1'b0;
    @(posedge ref_clk);
    {br_resolve, redirect, mt_done} <= 3'h0;
  endtask

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, ls_req, ls_kind, ls_we, ls_addr,
     ls_wdata, ls_spec, fch_req, fch_addr, fch_spec, fch_seq, fch_hit, fch_cacheable,
     tlb_guard, tlb_noexec, br_unresolved, br_resolve, br_mispredict, uncond_br_fetched,
     redirect, ind_br_pred, mt_issue, mt_done, trap_exec, rst_b} = '0;
    {wb_sel_i, ls_size, ls_cached} = {4'hf, `MSC_SZ_WORD, 1'b0};
    void'($urandom(32'h6509e086));
    d0 = $urandom;
    d1 = $urandom;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    for (int a = 0; a < 5; a++)
      wb(1'b0, 8'(a * 4), 32'h0);
    wb(1'b1, 8'h10, d0);
    wb(1'b0, 8'h10, 32'h0);
    wb(1'b1, `MSC_OFS_CTRL, 32'hffff_ffff);
    wb(1'b0, `MSC_OFS_CTRL, 32'h1);
    ls_addr <= {$urandom} & 32'hffff_fffc;
    ls(`MSC_K_NORM, 1'b1, 1'b0, {2'h0, d0});
    ls(`MSC_K_NORM, 1'b0, 1'b1, {2'h2, d0});
    ls(`MSC_K_LRES, 1'b0, 1'b0, {2'h2, d0});
    ls(`MSC_K_SCOND, 1'b1, 1'b0, {2'h1, d1});
    ls(`MSC_K_SCOND, 1'b1, 1'b0, {2'h0, ~d1});
    ls(`MSC_K_MULT, 1'b0, 1'b0, {2'h2, d1});
    ls(`MSC_K_CMGT, 1'b0, 1'b0, {2'h0, d1});
    for (int b = 5; b < 7; b++)
      ls(3'(b), 1'b0, 1'b0, {2'h0, d1});
    for (int c = 0; c < 2; c++) begin
      br_unresolved <= 1'b1;
      for (int i = 0; i <= (c ? 2 : 5); i++)
        fch({3'b100, c == 0}, 2'b10, i == (c ? 2 : 5) ? 6 : 99);
    end
    for (int s = 0; s < 3; s++) begin
      {trap_exec, mt_issue, uncond_br_fetched, ind_br_pred} <= {s == 0, s == 1, s == 2, s == 1};
      @(posedge ref_clk);
      {mt_issue, uncond_br_fetched} <= 2'h0;
      @(posedge ref_clk);
      fch({1'b1, s == 2, 2'b01}, 2'b10, 5);
    end
    for (int g = 1; g < 4; g++) begin
      {tlb_guard, tlb_noexec} <= 2'(g);
      fch(4'b0001, 2'b01, 99);
    end
    fch(4'b1011, 2'b10, 99);
    wb(1'b1, `MSC_OFS_CTRL, 32'h0);
    wb(1'b1, `MSC_OFS_GUARD, 32'hffff_ffff);
    wb(1'b0, `MSC_OFS_GUARD, 32'hffff_ffff);
    fch(4'b1010, 2'b10, 99);
    fch(4'b0000, 2'b10, 99);
    br_mispredict <= 1'b1;
    @(posedge ref_clk);
    br_mispredict <= 1'b0;
    @(posedge ref_clk);
    chk(34'h1, {33'h0, flush}, "flush");
    repeat (2) @(posedge ref_clk);
    finish_test();
  end

  initial begin
    #(20000 * 100);
    n_mismatch++;
    finish_test();
  end
endmodule // testbench
